// >>> scpu_regs.svh
// Purpose: constants for the script processor register and timer block
// Assumes: single clock, synchronous active-high reset
// Notes: timing counts derive from the clock rate
// How it works
// - A 16-bit auxiliary register sits beside the 16-bit accumulator.
// - The RAM index pointer addresses indexed add, compare, load, subtract, store.
// - Data RAM byte addresses run 0x000 to 0xfff, twelve bits.
// - An eight-deep return stack serves calls; instructions cannot touch it.
// - A 128-entry 16-bit data stack is reached only by push and pop.
// - Five 16-bit period counters count until stopped, saturating at 65535.
// - Cycle-count timer loads accept 0 to 2147483647 clock cycles.
// - Seconds timer loads accept 0 to 6000.
// - Three countdown timers, started by cycles or seconds, each with expiry flag.
// - Sixteen-bit immediates span 0 to 65535.
// - Byte immediates span 0 to 255.
// - The program counter is never an operand.
// - Loop counter loaded by set-count, used by decrement-and-branch.
// - Prompt display clears all response flags; a button then sets one.
// - Period counters start at 10us, 100us or 1ms tick; stop on end.
// - Starting a timer loads the count and clears expiry; run-out sets it.
// - Indexed byte store writes accumulator low byte at the index address.
`ifndef SCPU_REGS_SVH
`define SCPU_REGS_SVH
`define SCPU_CLOCK_HZ 40000000
`define SCPU_TICK_10US_NS 10000
`define SCPU_TICK_100US_NS 100000
`define SCPU_TICK_1MS_NS 1000000
`define SCPU_CYCLES_10US ((`SCPU_CLOCK_HZ / 1000000) * `SCPU_TICK_10US_NS / 1000)
`define SCPU_CYCLES_100US ((`SCPU_CLOCK_HZ / 1000000) * `SCPU_TICK_100US_NS / 1000)
`define SCPU_CYCLES_1MS ((`SCPU_CLOCK_HZ / 1000000) * `SCPU_TICK_1MS_NS / 1000)
`define SCPU_CYCLES_MAX 32'h7fffffff
`define SCPU_SECONDS_MAX 16'h1770
`define SCPU_RAM_ADDR_MAX 12'hfff
`define SCPU_PERIOD_MAX 16'hffff
`define SCPU_RESET_WORD 16'h0000
`define SCPU_ALU_LOAD 3'h0
`define SCPU_ALU_ADD 3'h1
`define SCPU_ALU_SUB 3'h2
`define SCPU_ALU_CMP 3'h3
`define SCPU_ALU_STORE 3'h4
`define SCPU_ALU_STORE_WORD 3'h5
`define SCPU_RATE_10US 2'h0
`define SCPU_RATE_100US 2'h1
`define SCPU_RATE_1MS 2'h2
`endif

// >>> scpu_pkg.sv
// Purpose: types of the script processor register block
// Assumes: constants come from scpu_regs.svh
// Notes: none
package scpu_pkg;
  typedef enum logic [1:0] {
    scpu_tmr_idle_type_s = 2'b00,
    scpu_tmr_run_s = 2'b01,
    scpu_tmr_done_s = 2'b10
  } scpu_tmr_state_type;
endpackage

// >>> scpu_countdown.sv
// Purpose: one countdown timer with expiry flag
// Assumes: cycle loads already in clock cycles; second loads are scaled here by SECOND_CYCLES
// Notes: a start in the expiry cycle wins
`timescale 1ns/10ps
`include "scpu_regs.svh"
module scpu_countdown #(
  parameter int SECOND_CYCLES = `SCPU_CLOCK_HZ
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Start commands
  input wire logic i_start_cycles,
  input wire logic i_start_seconds,
  input wire logic [30:0] i_cycles,
  input wire logic [12:0] i_seconds,
  // Status
  output logic o_expired,
  output logic o_running
);
  scpu_pkg::scpu_tmr_state_type state, next_state;
  logic [44:0] count, next_count;
  logic expired, next_expired;
  logic [44:0] sec_load;
  logic [12:0] sec_clip;

  always_comb begin
    sec_clip = (i_seconds > 13'(`SCPU_SECONDS_MAX)) ? 13'(`SCPU_SECONDS_MAX) : i_seconds;
    sec_load = 45'(sec_clip) * 45'(SECOND_CYCLES);
    next_state = state;
    next_count = count;
    next_expired = expired;
    case (state)
      scpu_pkg::scpu_tmr_run_s: begin
        if (count <= 45'h1) begin
          next_count = 45'h0;
          next_expired = 1'b1;
          next_state = scpu_pkg::scpu_tmr_done_s;
        end else begin
          next_count = count - 45'h1;
        end
      end
      scpu_pkg::scpu_tmr_idle_type_s, scpu_pkg::scpu_tmr_done_s: begin
        next_state = state;
      end
      default: begin
        next_state = scpu_pkg::scpu_tmr_idle_type_s;
      end
    endcase
    if (i_start_cycles || i_start_seconds) begin
      next_count = i_start_cycles ? 45'(i_cycles) : sec_load;
      next_expired = 1'b0;
      next_state = scpu_pkg::scpu_tmr_run_s;
      if (next_count == 45'h0) begin
        next_expired = 1'b1;
        next_state = scpu_pkg::scpu_tmr_done_s;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= scpu_pkg::scpu_tmr_idle_type_s;
      count <= 45'h0;
      expired <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      expired <= next_expired;
    end
  end

  assign o_expired = expired;
  assign o_running = (state == scpu_pkg::scpu_tmr_run_s);
endmodule // scpu_countdown

// >>> scpu_regs_timers.sv
// Purpose: architectural registers, stacks and timers of the script processor
// Assumes: sequencer issues at most one operation per cycle; strobes are one-cycle pulses
// Notes: data RAM is a byte array here; reads return one cycle later
`timescale 1ns/10ps
`include "scpu_regs.svh"
module scpu_regs_timers #(
  parameter int RAM_BYTES = 4096,
  parameter int CALL_DEPTH = 8,
  parameter int DATA_DEPTH = 128,
  parameter int PERIOD_COUNT = 5,
  parameter int TIMER_COUNT = 3,
  parameter int FLAG_COUNT = 8,
  parameter int SECOND_CYCLES = `SCPU_CLOCK_HZ,
  parameter int TICK_10US = `SCPU_CYCLES_10US,
  parameter int TICK_100US = `SCPU_CYCLES_100US,
  parameter int TICK_1MS = `SCPU_CYCLES_1MS
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Accumulator and aux register writes
  input wire logic i_acc_write,
  input wire logic [15:0] i_acc_value,
  input wire logic i_aux_register_write,
  input wire logic [15:0] i_aux_register_value,
  input wire logic i_swap_acc_aux,
  // RAM index pointer and indexed operations
  input wire logic i_ram_index_pointer_write,
  input wire logic [11:0] i_ram_index_pointer_value,
  input wire logic i_indexed_op,
  input wire logic [2:0] i_indexed_kind,
  input wire logic i_byte_immediate,
  input wire logic [7:0] i_byte_value,
  // Call stack
  input wire logic i_call,
  input wire logic i_return,
  input wire logic [11:0] i_return_address,
  // Data stack
  input wire logic i_push,
  input wire logic i_pop,
  // Loop counter
  input wire logic i_loop_counter_load,
  input wire logic [15:0] i_loop_counter_value,
  input wire logic i_decrement_branch_nonzero,
  // Countdown timers
  input wire logic [TIMER_COUNT-1:0] i_countdown_start_cycles,
  input wire logic [TIMER_COUNT-1:0] i_countdown_start_seconds,
  input wire logic [30:0] i_countdown_cycles,
  input wire logic [12:0] i_countdown_seconds,
  // Period counters
  input wire logic [PERIOD_COUNT-1:0] i_period_measure_start,
  input wire logic [1:0] i_period_rate,
  input wire logic [PERIOD_COUNT-1:0] i_period_measure_stop,
  // User prompt
  input wire logic i_user_prompt_display,
  input wire logic [FLAG_COUNT-1:0] i_user_button,
  // Register state
  output logic [15:0] o_acc,
  output logic [15:0] o_aux_register,
  output logic [11:0] o_ram_index_pointer,
  output logic [15:0] o_ram_data,
  output logic o_compare_equal,
  output logic [11:0] o_return_target,
  output logic o_call_overflow,
  output logic [15:0] o_stack_top,
  output logic o_stack_overflow,
  output logic [15:0] o_loop_counter,
  output logic o_branch_taken,
  // Timers and response flags
  output logic [TIMER_COUNT-1:0] o_countdown_expired_flag,
  output logic [TIMER_COUNT-1:0] o_countdown_running,
  output logic [PERIOD_COUNT*16-1:0] o_period_measure_counter,
  output logic [FLAG_COUNT-1:0] o_response_flag
);
  localparam int CW = $clog2(CALL_DEPTH + 1);
  localparam int DW = $clog2(DATA_DEPTH + 1);

  logic [7:0] ram [RAM_BYTES];
  logic [11:0] call_stack [CALL_DEPTH];
  logic [15:0] data_stack [DATA_DEPTH];

  logic [15:0] acc, next_acc;
  logic [15:0] aux, next_aux;
  logic [11:0] index, next_index;
  logic [15:0] ram_data, next_ram_data;
  logic cmp_eq, next_cmp_eq;
  logic [CW-1:0] call_ptr, next_call_ptr;
  logic call_ovf, next_call_ovf;
  logic [DW-1:0] data_ptr, next_data_ptr;
  logic stack_ovf, next_stack_ovf;
  logic [15:0] loop_cnt, next_loop_cnt;
  logic branch, next_branch;
  logic [FLAG_COUNT-1:0] resp, next_resp;
  logic [15:0] operand;
  logic [15:0] ram_word;
  logic [11:0] index_hi;

  // Indexed operand: byte immediate or RAM byte at the index
  always_comb begin
    index_hi = index + 12'h1;
    ram_word = {ram[index_hi], ram[index]};
    operand = i_byte_immediate ? {8'h00, i_byte_value} : {8'h00, ram[index]};
  end

  always_comb begin
    next_acc = acc;
    next_aux = aux;
    next_index = index;
    next_ram_data = ram_data;
    next_cmp_eq = cmp_eq;
    if (i_acc_write) begin
      next_acc = i_acc_value;
    end
    if (i_aux_register_write) begin
      next_aux = i_aux_register_value;
    end
    if (i_swap_acc_aux) begin
      next_acc = aux;
      next_aux = acc;
    end
    if (i_ram_index_pointer_write) begin
      next_index = i_ram_index_pointer_value & `SCPU_RAM_ADDR_MAX;
    end
    if (i_indexed_op) begin
      case (i_indexed_kind)
        `SCPU_ALU_LOAD: begin
          next_acc = operand;
          next_ram_data = ram_word;
        end
        `SCPU_ALU_ADD: begin
          next_acc = acc + operand;
        end
        `SCPU_ALU_SUB: begin
          next_acc = acc - operand;
        end
        `SCPU_ALU_CMP: begin
          next_cmp_eq = (acc[7:0] == operand[7:0]);
        end
        default: begin
          next_ram_data = ram_word;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      acc <= `SCPU_RESET_WORD;
      aux <= `SCPU_RESET_WORD;
      index <= 12'h000;
      ram_data <= `SCPU_RESET_WORD;
      cmp_eq <= 1'b0;
    end else begin
      acc <= next_acc;
      aux <= next_aux;
      index <= next_index;
      ram_data <= next_ram_data;
      cmp_eq <= next_cmp_eq;
    end
  end

  // Data RAM writes, no reset on storage
  always_ff @(posedge i_clock) begin
    if (!i_rst && i_indexed_op && (i_indexed_kind == `SCPU_ALU_STORE)) begin
      ram[index] <= acc[7:0];
    end
    if (!i_rst && i_indexed_op && (i_indexed_kind == `SCPU_ALU_STORE_WORD)) begin
      ram[index] <= acc[7:0];
      ram[index_hi] <= acc[15:8];
    end
  end

  // Call and data stacks; pointer state only
  always_comb begin
    next_call_ptr = call_ptr;
    next_call_ovf = call_ovf;
    next_data_ptr = data_ptr;
    next_stack_ovf = stack_ovf;
    if (i_call) begin
      if (call_ptr == CW'(CALL_DEPTH)) begin
        next_call_ovf = 1'b1;
      end else begin
        next_call_ptr = call_ptr + CW'(1);
      end
    end else if (i_return && (call_ptr != CW'(0))) begin
      next_call_ptr = call_ptr - CW'(1);
    end
    if (i_push) begin
      if (data_ptr == DW'(DATA_DEPTH)) begin
        next_stack_ovf = 1'b1;
      end else begin
        next_data_ptr = data_ptr + DW'(1);
      end
    end else if (i_pop && (data_ptr != DW'(0))) begin
      next_data_ptr = data_ptr - DW'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      call_ptr <= '0;
      call_ovf <= 1'b0;
      data_ptr <= '0;
      stack_ovf <= 1'b0;
    end else begin
      call_ptr <= next_call_ptr;
      call_ovf <= next_call_ovf;
      data_ptr <= next_data_ptr;
      stack_ovf <= next_stack_ovf;
    end
  end

  // Stack storage; no path from any operand port into the return stack
  always_ff @(posedge i_clock) begin
    if (!i_rst && i_call && (call_ptr != CW'(CALL_DEPTH))) begin
      call_stack[call_ptr[CW-2:0]] <= i_return_address;
    end
    if (!i_rst && i_push && (data_ptr != DW'(DATA_DEPTH))) begin
      data_stack[data_ptr[DW-2:0]] <= acc;
    end
  end

  // Loop counter and response flags
  always_comb begin
    next_loop_cnt = loop_cnt;
    next_branch = 1'b0;
    next_resp = resp;
    if (i_loop_counter_load) begin
      next_loop_cnt = i_loop_counter_value;
    end else if (i_decrement_branch_nonzero) begin
      next_loop_cnt = loop_cnt - 16'h1;
      next_branch = (loop_cnt != 16'h1);
    end
    if (i_user_prompt_display) begin
      next_resp = '0;
    end
    next_resp = next_resp | i_user_button;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      loop_cnt <= `SCPU_RESET_WORD;
      branch <= 1'b0;
      resp <= '0;
    end else begin
      loop_cnt <= next_loop_cnt;
      branch <= next_branch;
      resp <= next_resp;
    end
  end

  // Countdown timers
  for (genvar t = 0; t < TIMER_COUNT; t++) begin : g_timer
    scpu_countdown #(
      .SECOND_CYCLES(SECOND_CYCLES)
    ) u_countdown (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_start_cycles(i_countdown_start_cycles[t]),
      .i_start_seconds(i_countdown_start_seconds[t]),
      .i_cycles(i_countdown_cycles),
      .i_seconds(i_countdown_seconds),
      .o_expired(o_countdown_expired_flag[t]),
      .o_running(o_countdown_running[t])
    );
  end

  // Period counters with per-counter tick prescaler
  for (genvar p = 0; p < PERIOD_COUNT; p++) begin : g_period
    logic [15:0] cnt, next_cnt;
    logic [15:0] pre, next_pre;
    logic [15:0] pre_top, next_pre_top;
    logic run, next_run;
    always_comb begin
      next_cnt = cnt;
      next_pre = pre;
      next_pre_top = pre_top;
      next_run = run;
      if (i_period_measure_start[p]) begin
        next_run = 1'b1;
        next_cnt = 16'h0;
        next_pre = 16'h0;
        case (i_period_rate)
          `SCPU_RATE_10US: next_pre_top = 16'(TICK_10US - 1);
          `SCPU_RATE_100US: next_pre_top = 16'(TICK_100US - 1);
          default: next_pre_top = 16'(TICK_1MS - 1);
        endcase
      end else if (i_period_measure_stop[p]) begin
        next_run = 1'b0;
      end else if (run) begin
        if (pre >= pre_top) begin
          next_pre = 16'h0;
          if (cnt != `SCPU_PERIOD_MAX) begin
            next_cnt = cnt + 16'h1;
          end
        end else begin
          next_pre = pre + 16'h1;
        end
      end
    end
    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        cnt <= 16'h0;
        pre <= 16'h0;
        pre_top <= 16'h0;
        run <= 1'b0;
      end else begin
        cnt <= next_cnt;
        pre <= next_pre;
        pre_top <= next_pre_top;
        run <= next_run;
      end
    end
    assign o_period_measure_counter[p*16 +: 16] = cnt;
  end

  assign o_acc = acc;
  assign o_aux_register = aux;
  assign o_ram_index_pointer = index;
  assign o_ram_data = ram_data;
  assign o_compare_equal = cmp_eq;
  assign o_return_target = (call_ptr == CW'(0)) ? 12'h000 : call_stack[3'(call_ptr - CW'(1))];
  assign o_call_overflow = call_ovf;
  assign o_stack_top = (data_ptr == DW'(0)) ? 16'h0000 : data_stack[7'(data_ptr - DW'(1))];
  assign o_stack_overflow = stack_ovf;
  assign o_loop_counter = loop_cnt;
  assign o_branch_taken = branch;
  assign o_response_flag = resp;
endmodule // scpu_regs_timers

// >>> scpu_regs_timers_monitor.sv
// Purpose: port-level checks of the register and timer block
// Assumes: one clock, synchronous active-high reset
// Notes: attached to every instance by the bind below
`timescale 1ns/10ps
module scpu_regs_timers_monitor #(
  parameter int PERIOD_COUNT = 5,
  parameter int TIMER_COUNT = 3,
  parameter int FLAG_COUNT = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Watched inputs
  input wire logic i_acc_write,
  input wire logic [15:0] i_acc_value,
  input wire logic i_swap_acc_aux,
  input wire logic i_indexed_op,
  input wire logic i_loop_counter_load,
  input wire logic i_decrement_branch_nonzero,
  input wire logic [TIMER_COUNT-1:0] i_countdown_start_cycles,
  input wire logic [TIMER_COUNT-1:0] i_countdown_start_seconds,
  input wire logic [PERIOD_COUNT-1:0] i_period_measure_start,
  input wire logic [PERIOD_COUNT-1:0] i_period_measure_stop,
  input wire logic i_user_prompt_display,
  input wire logic [FLAG_COUNT-1:0] i_user_button,
  // Watched outputs
  input wire logic [15:0] o_acc,
  input wire logic [15:0] o_aux_register,
  input wire logic [15:0] o_loop_counter,
  input wire logic o_branch_taken,
  input wire logic [TIMER_COUNT-1:0] o_countdown_expired_flag,
  input wire logic [PERIOD_COUNT*16-1:0] o_period_measure_counter,
  input wire logic [FLAG_COUNT-1:0] o_response_flag
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [15:0] period0;
  assign period0 = o_period_measure_counter[15:0];
  sequence s_decrement;
    i_decrement_branch_nonzero && !i_loop_counter_load;
  endsequence
  sequence s_stop_held;
    (i_period_measure_stop[0] && !i_period_measure_start[0]) ##1 !i_period_measure_start[0];
  endsequence
  a_acc_write_load: assert property (
    i_acc_write && !i_swap_acc_aux && !i_indexed_op |=> o_acc == $past(i_acc_value))
    else $error("acc load");
  a_swap_exchange: assert property (i_swap_acc_aux && !i_indexed_op |=>
    o_acc == $past(o_aux_register) && o_aux_register == $past(o_acc)) else $error("swap");
  a_branch_taken: assert property (s_decrement ##0 o_loop_counter > 16'h0001 |=>
    o_branch_taken && o_loop_counter == $past(o_loop_counter) - 16'h0001) else $error("branch");
  a_branch_fall: assert property (s_decrement ##0 o_loop_counter == 16'h0001 |=>
    !o_branch_taken && o_loop_counter == 16'h0000) else $error("fall through");
  a_expiry_hold: assert property (o_countdown_expired_flag[0] &&
    !i_countdown_start_cycles[0] && !i_countdown_start_seconds[0] |=>
    o_countdown_expired_flag[0]) else $error("expiry flag lost");
  a_prompt_flags: assert property (i_user_prompt_display |=>
    o_response_flag == $past(i_user_button)) else $error("response flags");
  a_period_saturate: assert property (
    period0 == 16'hffff && !i_period_measure_start[0] |=> period0 == 16'hffff)
    else $error("period saturation");
  a_period_freeze: assert property (s_stop_held |=> $stable(period0))
    else $error("period stop");
endmodule // scpu_regs_timers_monitor
bind scpu_regs_timers scpu_regs_timers_monitor #(
  .PERIOD_COUNT(PERIOD_COUNT), .TIMER_COUNT(TIMER_COUNT), .FLAG_COUNT(FLAG_COUNT)
) i_monitor (.*);

// >>> testbench.sv
// Purpose: self-checking bench for the register and timer block
// Assumes: shortened tick and second counts
// Notes: a bench model tracks every result
`timescale 1ns/10ps
module testbench;
  localparam int SEC = 10;
  localparam int TK [4] = '{1, 3, 5, 5};
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_acc_write, i_aux_register_write, i_swap_acc_aux, i_ram_index_pointer_write;
  logic i_indexed_op, i_byte_immediate, i_call, i_return, i_push, i_pop;
  logic i_loop_counter_load, i_decrement_branch_nonzero, i_user_prompt_display;
  logic [15:0] i_acc_value, i_aux_register_value, i_loop_counter_value;
  logic [11:0] i_ram_index_pointer_value, i_return_address;
  logic [2:0] i_indexed_kind, i_countdown_start_cycles, i_countdown_start_seconds;
  logic [7:0] i_byte_value, i_user_button;
  logic [30:0] i_countdown_cycles;
  logic [12:0] i_countdown_seconds;
  logic [4:0] i_period_measure_start, i_period_measure_stop;
  logic [1:0] i_period_rate;
  logic [15:0] o_acc, o_aux_register, o_ram_data, o_stack_top, o_loop_counter;
  logic [11:0] o_ram_index_pointer, o_return_target;
  logic o_compare_equal, o_call_overflow, o_stack_overflow, o_branch_taken;
  logic [2:0] o_countdown_expired_flag, o_countdown_running;
  logic [79:0] o_period_measure_counter;
  logic [7:0] o_response_flag;
  logic [7:0] ram [4096];
  int acc, aux, idx, fl, i, k, v, n_fail, n_compared;
  int q [$];
  always #12.5 i_clock = ~i_clock;
  scpu_regs_timers #(.SECOND_CYCLES(SEC), .TICK_10US(1), .TICK_100US(3), .TICK_1MS(5))
    i_dut (.*);
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic clear;
    {i_acc_write, i_aux_register_write, i_swap_acc_aux, i_ram_index_pointer_write,
     i_indexed_op, i_byte_immediate, i_call, i_return, i_push, i_pop, i_loop_counter_load,
     i_decrement_branch_nonzero, i_user_prompt_display, i_indexed_kind, i_user_button,
     i_countdown_start_cycles, i_countdown_start_seconds, i_period_measure_start,
     i_period_measure_stop} = '0;
  endtask
  // Strobes stand one cycle, then one idle cycle
  task automatic fire;
    @(negedge i_clock);
    clear();
    @(negedge i_clock);
  endtask
  task automatic ind(int kind, logic imm, logic [7:0] b);
    logic [7:0] op;
    op = imm ? b : ram[idx];
    i_indexed_op = 1'b1;
    i_indexed_kind = kind[2:0];
    i_byte_immediate = imm;
    i_byte_value = b;
    fire();
    case (kind)
      0: begin
        acc = op;
        check("ram_data", o_ram_data, {ram[(idx + 1) % 4096], ram[idx]});
      end
      1: acc = (acc + op) & 16'hffff;
      2: acc = (acc - op) & 16'hffff;
      3: check("compare", o_compare_equal, acc[7:0] == op);
      4: ram[idx] = acc[7:0];
      default: begin
        ram[idx] = acc[7:0];
        ram[(idx + 1) % 4096] = acc[15:8];
      end
    endcase
    if (kind <= 2) check("acc", o_acc, acc);
  endtask
  task automatic stack_test(logic c, int depth);
    for (i = 0; i <= depth; i++) begin
      v = c ? $urandom_range(12'hfff) : $urandom_range(16'hffff);
      i_acc_write = !c;
      i_acc_value = v[15:0];
      fire();
      i_call = c;
      i_return_address = v[11:0];
      i_push = !c;
      fire();
      if (i < depth) q.push_back(v);
      check("top", c ? o_return_target : o_stack_top, q[$]);
      check("overflow", c ? o_call_overflow : o_stack_overflow, i == depth);
    end
    while (q.size() > 0) begin
      check("top", c ? o_return_target : o_stack_top, q.pop_back());
      i_return = c;
      i_pop = !c;
      fire();
    end
    i_return = c;
    i_pop = !c;
    fire();
    check("top", c ? o_return_target : o_stack_top, 0);
  endtask
  task automatic wait_flag(int t, int n);
    int c;
    c = 1;
    check("expired", o_countdown_expired_flag[t], 0);
    while (o_countdown_expired_flag[t] !== 1'b1) begin
      @(negedge i_clock);
      c++;
      if (c > n + 50) begin
        n_fail++;
        give_verdict();
      end
    end
    check("expiry_time", c, n);
  endtask
  initial begin
    void'($urandom(4));
    clear();
    {i_acc_value, i_aux_register_value, i_loop_counter_value, i_ram_index_pointer_value,
     i_return_address, i_byte_value, i_countdown_cycles, i_countdown_seconds,
     i_period_rate} = '0;
    repeat (4) @(negedge i_clock);
    i_rst = 1'b0;
    @(negedge i_clock);
    check("acc", o_acc, 0);
    check("flags", o_response_flag, 0);
    for (i = 0; i < 4; i++) begin
      acc = i ? $urandom_range(16'hffff) : 16'hffff;
      aux = $urandom_range(16'hffff);
      i_acc_write = 1'b1;
      i_acc_value = acc[15:0];
      i_aux_register_write = 1'b1;
      i_aux_register_value = aux[15:0];
      fire();
      check("aux", o_aux_register, aux);
      i_swap_acc_aux = 1'b1;
      fire();
      v = acc;
      acc = aux;
      aux = v;
      check("acc", o_acc, acc);
      check("aux", o_aux_register, aux);
    end
    idx = 12'hfff;
    i_ram_index_pointer_write = 1'b1;
    i_ram_index_pointer_value = 12'hfff;
    fire();
    check("index", o_ram_index_pointer, idx);
    for (k = 0; k < 12; k++) begin
      ind(5 - k % 6, k >= 8, (k == 8) ? acc[7:0] : (k == 10) ? 8'hff : 8'($urandom));
    end
    stack_test(1'b0, 128);
    stack_test(1'b1, 8);
    i_loop_counter_load = 1'b1;
    i_loop_counter_value = 16'h0003;
    fire();
    check("loop", o_loop_counter, 3);
    i_decrement_branch_nonzero = 1'b1;
    for (k = 2; k >= 0; k--) begin
      @(negedge i_clock);
      check("loop", o_loop_counter, k);
      check("branch", o_branch_taken, k != 0);
    end
    i_decrement_branch_nonzero = 1'b0;
    for (k = 0; k < 3; k++) begin
      i_countdown_start_cycles[k] = 1'b1;
      i_countdown_cycles = 31'h7fffffff;
      fire();
      check("running", o_countdown_running[k], 1);
      v = 3 + $urandom_range(20);
      i_countdown_start_cycles[k] = 1'b1;
      i_countdown_cycles = v[30:0];
      fire();
      wait_flag(k, v);
      i_countdown_start_seconds[k] = 1'b1;
      i_countdown_seconds = 13'(k + 1);
      fire();
      wait_flag(k, (k + 1) * SEC);
    end
    for (k = 0; k < 5; k++) begin
      i_period_measure_start[k] = 1'b1;
      i_period_rate = 2'(k % 4);
      fire();
      repeat (40) @(negedge i_clock);
      i_period_measure_stop[k] = 1'b1;
      fire();
      v = o_period_measure_counter[k*16 +: 16];
      repeat (5) @(negedge i_clock);
      check("period", o_period_measure_counter[k*16 +: 16], v);
      check("rate", v, 41 / TK[k % 4]);
    end
    i_period_measure_start[0] = 1'b1;
    i_period_rate = 2'h0;
    i_countdown_start_seconds[0] = 1'b1;
    i_countdown_seconds = 13'h1fff;
    fire();
    wait_flag(0, 6000 * SEC);
    repeat (65540 - 6000 * SEC) @(negedge i_clock);
    check("saturate", o_period_measure_counter[15:0], 16'hffff);
    for (i = 0; i < 6; i++) begin
      i_user_prompt_display = i[0];
      i_user_button = (i % 3 == 1) ? 8'h00 : 8'($urandom);
      v = i_user_button;
      fire();
      fl = i[0] ? v : fl | v;
      check("flags", o_response_flag, fl);
    end
    give_verdict();
  end
endmodule // testbench
